// ===== rtl/pcsdp_top.sv
// Purpose: per-channel pcs datapath controls, 8b/10b and 64b/66b sides
// Assumes: all inputs synchronous to pclk; one code group per cycle
// Notes:   registers over apb, zero wait state, one word each
//
// How it works
// - at least three K28.5 after tx reset
// - comma on odd boundary forces sync loss
// - fec only with 64b/66b pcs enabled
// - fec adds forty cycles over tx plus rx
// - repeated commas alternate disparity when unforced
// - forced disparity: low value gives positive
// - force and value controls, one bit per channel
// - phase mode: same clock, constant depth
// - rx valid steady or toggling per gear ratio in basic and clock comp modes
// - register mode gives deterministic latency
// - 10g: tx phase, rx clock compensation
// - 10g with 1588: both fifos register mode
// - 10g with fec: tx phase, rx clock comp
// - tx polarity inverted while its bit high
// - rx polarity inverted while its bit high
// - polarity inversion on both pcs kinds
// - sync status high when synced, low on loss
`timescale 1ns/100ps
module pcsdp_top #(
  parameter int NCH   = 2,
  parameter int ENH_W = 64,
  parameter int DEPTH = 8
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [pcsdp_pkg::APB_AW-1:0] paddr,
  input  wire logic [pcsdp_pkg::APB_DW-1:0] pwdata,
  output logic      [pcsdp_pkg::APB_DW-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         tx_pcs_rst,
  input  wire logic [NCH*8-1:0]             tx_byte,
  input  wire logic [NCH-1:0]               tx_is_k,
  input  wire logic [NCH-1:0]               tx_forcedisp,
  input  wire logic [NCH-1:0]               tx_dispval,
  input  wire logic [NCH-1:0]               tx_polinv,
  output logic      [NCH*10-1:0]            tx_code,
  output logic                              tx_user_ready,
  input  wire logic                         rx_pcs_rst,
  input  wire logic [NCH*10-1:0]            rx_code,
  input  wire logic [NCH-1:0]               rx_polinv,
  output logic      [NCH*10-1:0]            rx_word,
  output logic      [NCH-1:0]               rx_syncstatus,
  input  wire logic [ENH_W-1:0]             tx_enh_data,
  input  wire logic                         tx_enh_wr_en,
  output logic                              tx_enh_pfull,
  output logic      [ENH_W-1:0]             tx_enh_word,
  output logic                              tx_enh_word_valid,
  input  wire logic [ENH_W-1:0]             rx_enh_word_in,
  input  wire logic                         rx_enh_word_in_valid,
  input  wire logic                         rx_enh_read_en,
  output logic      [ENH_W-1:0]             rx_enh_data,
  output logic                              rx_enh_data_valid,
  output logic                              rx_enh_pempty
);
  import pcsdp_pkg::*;

  localparam int CC_W  = $clog2(COMMA_MIN + 1);
  localparam int FEC_PW = $clog2(FEC_HALF);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  pcsdp_ctrl_s          ctrl_r;
  pcsdp_ctrl_s          ctrl_wr;
  logic [APB_DW-1:0]    prdata_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic                 apb_setup;
  logic                 apb_write;
  logic                 addr_hit;
  logic [APB_DW-1:0]    rd_word;
  logic [APB_DW-1:0]    status_word;

  logic [CC_W-1:0]      comma_cnt_r;
  logic                 tx_ready_r;
  logic                 send_comma;
  logic [NCH-1:0]       rd_r;
  pcsdp_enc_s           enc [NCH];
  logic [NCH*10-1:0]    tx_code_r;

  logic [NCH*10-1:0]    rx_inv;
  logic [NCH*10-1:0]    rx_word_r;
  logic [NCH-1:0]       rx_comma;
  logic [NCH-1:0]       pos_odd_r;
  pcsdp_sync_e          sync_r   [NCH];
  pcsdp_sync_e          sync_nxt [NCH];
  logic [NCH-1:0]       sync_st_r;

  pcsdp_fifo_e          tx_mode_eff;
  pcsdp_fifo_e          rx_mode_eff;
  logic                 fec_active;
  logic [FEC_PW-1:0]    fec_ptr_r;
  logic [ENH_W:0]       fec_tx_mem [FEC_HALF];
  logic [ENH_W:0]       fec_rx_mem [FEC_HALF];
  logic [ENH_W:0]       tx_pre;
  logic [ENH_W:0]       rx_pre;
  logic [ENH_W:0]       tx_sel;
  logic [ENH_W:0]       rx_sel;
  logic [ENH_W-1:0]     tx_fifo_data;
  logic                 tx_fifo_valid;
  logic [ENH_W-1:0]     rx_fifo_data;
  logic                 rx_fifo_valid;
  logic [ENH_W-1:0]     tx_enh_word_r;
  logic                 tx_enh_valid_r;
  logic [ENH_W-1:0]     rx_enh_data_r;
  logic                 rx_enh_valid_r;
  logic                 gear_ph_r;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: read data captured in setup, write taken and answered in the first access cycle
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready_r && pwrite;
  assign addr_hit  = paddr inside {CTRL_OFS, STATUS_OFS, LAT_OFS};

  always_comb begin
    status_word                         = '0;
    status_word[NCH-1:0]                = sync_st_r;
    status_word[ST_TXRDY]               = tx_ready_r;
    status_word[ST_TXPFULL]             = tx_enh_pfull;
    status_word[ST_RXPEMPTY]            = rx_enh_pempty;
    status_word[ST_FEC]                 = fec_active;
    status_word[ST_TXMODE +: 2]         = tx_mode_eff;
    status_word[ST_RXMODE +: 2]         = rx_mode_eff;
    case (paddr)
      CTRL_OFS:   rd_word = APB_DW'(ctrl_r);
      STATUS_OFS: rd_word = status_word;
      LAT_OFS:    rd_word = fec_active ? APB_DW'(FEC_LAT_CYC) : '0;
      default:    rd_word = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup && !addr_hit;
      if (apb_setup && !pwrite)
        prdata_r <= rd_word;
    end
  end

  // fec request dropped unless the 64b/66b pcs is chosen
  always_comb begin
    ctrl_wr        = pcsdp_ctrl_s'(pwdata[CTRL_W-1:0]);
    ctrl_wr.fec_en = ctrl_wr.fec_en && ctrl_wr.pcs_enh;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_r <= pcsdp_ctrl_s'(CTRL_RST[CTRL_W-1:0]);
    else if (apb_write && paddr == CTRL_OFS)
      ctrl_r <= ctrl_wr;
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // 8b/10b transmit: comma burst after reset, disparity control
  assign send_comma = !tx_pcs_rst && !tx_ready_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comma_cnt_r <= '0;
      tx_ready_r  <= 1'b0;
    end else if (tx_pcs_rst) begin
      comma_cnt_r <= '0;
      tx_ready_r  <= 1'b0;
    end else if (!tx_ready_r) begin
      comma_cnt_r <= comma_cnt_r + 1'b1;
      if (comma_cnt_r == CC_W'(COMMA_MIN - 1))
        tx_ready_r <= 1'b1; // user data only after the burst
    end
  end

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      // forced value low selects the positive column
      enc[ch] = pcsdp_encode(
        send_comma ? K28_5_BYTE : tx_byte[ch*8 +: 8],
        send_comma || tx_is_k[ch],
        tx_forcedisp[ch] ? !tx_dispval[ch] : rd_r[ch]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r      <= {NCH{RD_NEG}};
      tx_code_r <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (tx_pcs_rst) begin
          rd_r[ch]               <= RD_NEG;
          tx_code_r[ch*10 +: 10] <= '0;
        end else begin
          // running disparity carried forward keeps commas alternating
          rd_r[ch]               <= enc[ch].rd;
          // complement of the whole group before serializing
          tx_code_r[ch*10 +: 10] <= enc[ch].code ^ {10{tx_polinv[ch]}};
        end
      end
    end
  end

  assign tx_code       = tx_code_r;
  assign tx_user_ready = tx_ready_r;

  ////////////////////////////////////////////////////////////////////////
  // receive: polarity, comma detection, synchronization
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      // inverted after deserializing, ahead of alignment
      rx_inv[ch*10 +: 10] = rx_code[ch*10 +: 10] ^ {10{rx_polinv[ch]}};
      rx_comma[ch] = rx_inv[ch*10 +: 10] == K28_5_RDN ||
                     rx_inv[ch*10 +: 10] == K28_5_RDP;
    end
  end

  // pos_odd_r: distance from the last comma is odd; a comma there means
  // an even count of data groups in between
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      sync_nxt[ch] = sync_r[ch];
      case (sync_r[ch])
        SYNC_LOSS: if (rx_comma[ch]) begin
          sync_nxt[ch] = SYNC_ACQ1;
        end
        SYNC_ACQ1: if (rx_comma[ch]) begin
          sync_nxt[ch] = pos_odd_r[ch] ? SYNC_LOSS : SYNC_ACQ2;
        end
        SYNC_ACQ2: if (rx_comma[ch]) begin
          sync_nxt[ch] = pos_odd_r[ch] ? SYNC_LOSS : SYNC_OK;
        end
        SYNC_OK: if (rx_comma[ch] && pos_odd_r[ch]) begin
          sync_nxt[ch] = SYNC_LOSS;
        end
        default: sync_nxt[ch] = SYNC_LOSS;
      endcase
      if (rx_pcs_rst)
        sync_nxt[ch] = SYNC_LOSS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_odd_r <= '0;
      sync_st_r <= '0;
      rx_word_r <= '0;
      for (int ch = 0; ch < NCH; ch++)
        sync_r[ch] <= SYNC_LOSS;
    end else begin
      rx_word_r <= rx_inv;
      for (int ch = 0; ch < NCH; ch++) begin
        sync_r[ch]    <= sync_nxt[ch];
        pos_odd_r[ch] <= rx_comma[ch] ? 1'b1 : !pos_odd_r[ch];
        sync_st_r[ch] <= sync_nxt[ch] == SYNC_OK;
      end
    end
  end

  assign rx_word       = rx_word_r;
  assign rx_syncstatus = sync_st_r;

  ////////////////////////////////////////////////////////////////////////
  // 64b/66b side: fifo modes forced by the chosen configuration
  always_comb begin
    case (ctrl_r.cfg)
      CFG_TENG: begin
        tx_mode_eff = FIFO_PHASE;
        rx_mode_eff = FIFO_CLKCOMP;
      end
      CFG_TENG_1588: begin
        // compensation then lives in user logic
        tx_mode_eff = FIFO_REG;
        rx_mode_eff = FIFO_REG;
      end
      CFG_TENG_FEC: begin
        tx_mode_eff = FIFO_PHASE;
        rx_mode_eff = FIFO_CLKCOMP;
      end
      default: begin
        tx_mode_eff = ctrl_r.tx_mode;
        rx_mode_eff = ctrl_r.rx_mode;
      end
    endcase
  end

  assign fec_active = ctrl_r.pcs_enh &&
                      (ctrl_r.fec_en || ctrl_r.cfg == CFG_TENG_FEC);

  // serializer side drains one word a cycle; user throttles on pfull
  pcsdp_core_fifo #(
    .W          (ENH_W),
    .DEPTH      (DEPTH),
    .PFULL_LVL  (DEPTH - 2),
    .PEMPTY_LVL (2),
    .PHASE_LVL  (2)
  ) u_tx_fifo (
    .clk      (pclk),
    .rst_n    (presetn),
    .mode     (tx_mode_eff),
    .wr_en    (tx_enh_wr_en),
    .wr_data  (tx_enh_data),
    .rd_en    (1'b1),
    .rd_data  (tx_fifo_data),
    .rd_valid (tx_fifo_valid),
    .pfull    (tx_enh_pfull),
    .pempty   ()
  );

  ////////////////////////////////////////////////////////////////////////
  // fec latency: one delay line per direction, half the total each;
  // a real codec sits here, only its timing is kept
  assign tx_pre = {tx_fifo_valid, tx_fifo_data};
  assign rx_pre = {rx_enh_word_in_valid,
                   rx_enh_word_in ^ {ENH_W{rx_polinv[0]}}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fec_ptr_r <= '0;
      for (int i = 0; i < FEC_HALF; i++) begin
        fec_tx_mem[i] <= '0;
        fec_rx_mem[i] <= '0;
      end
    end else begin
      fec_ptr_r <= (fec_ptr_r == FEC_PW'(FEC_HALF - 1)) ?
                   '0 : fec_ptr_r + 1'b1;
      fec_tx_mem[fec_ptr_r] <= tx_pre;
      fec_rx_mem[fec_ptr_r] <= rx_pre;
    end
  end

  assign tx_sel = fec_active ? fec_tx_mem[fec_ptr_r] : tx_pre;
  assign rx_sel = fec_active ? fec_rx_mem[fec_ptr_r] : rx_pre;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enh_word_r  <= '0;
      tx_enh_valid_r <= 1'b0;
    end else begin
      // same complement as the 8b/10b lane
      tx_enh_word_r  <= tx_sel[ENH_W-1:0] ^ {ENH_W{tx_polinv[0]}};
      tx_enh_valid_r <= tx_sel[ENH_W] && ctrl_r.pcs_enh;
    end
  end

  assign tx_enh_word       = tx_enh_word_r;
  assign tx_enh_word_valid = tx_enh_valid_r;

  ////////////////////////////////////////////////////////////////////////
  // receive fifo; uneven gear ratio yields data every other cycle in basic and clock comp modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gear_ph_r <= 1'b1;
    else
      gear_ph_r <= ctrl_r.gear_uneven ? !gear_ph_r : 1'b1;
  end

  pcsdp_core_fifo #(
    .W          (ENH_W),
    .DEPTH      (DEPTH),
    .PFULL_LVL  (DEPTH - 2),
    .PEMPTY_LVL (2),
    .PHASE_LVL  (2)
  ) u_rx_fifo (
    .clk      (pclk),
    .rst_n    (presetn),
    .mode     (rx_mode_eff),
    .wr_en    (rx_sel[ENH_W]),
    .wr_data  (rx_sel[ENH_W-1:0]),
    .rd_en    (rx_enh_read_en && gear_ph_r),
    .rd_data  (rx_fifo_data),
    .rd_valid (rx_fifo_valid),
    .pfull    (),
    .pempty   (rx_enh_pempty)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enh_data_r  <= '0;
      rx_enh_valid_r <= 1'b0;
    end else begin
      rx_enh_data_r  <= rx_fifo_data;
      // low marks a word the user must discard
      rx_enh_valid_r <= rx_fifo_valid && ctrl_r.pcs_enh;
    end
  end

  assign rx_enh_data       = rx_enh_data_r;
  assign rx_enh_data_valid = rx_enh_valid_r;

endmodule

// ===== inc/pcsdp_pkg.sv
// Purpose: shared constants, types and coding tables of the pcs datapath
// Assumes: one pclk domain, registers one aligned 32-bit word each
// Notes:   code groups are {abcdei, fghj} with bit a as the msb
package pcsdp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam int           APB_AW      = 8;
  localparam int           APB_DW      = 32;
  localparam logic [7:0]   CTRL_OFS    = 8'h00;
  localparam logic [7:0]   STATUS_OFS  = 8'h04;
  localparam logic [7:0]   LAT_OFS     = 8'h08;
  localparam logic [31:0]  CTRL_RST    = 32'h0000_0000;
  localparam int           CTRL_W      = 9;
  localparam int           ST_TXRDY    = 8;
  localparam int           ST_TXPFULL  = 9;
  localparam int           ST_RXPEMPTY = 10;
  localparam int           ST_FEC      = 11;
  localparam int           ST_TXMODE   = 12;
  localparam int           ST_RXMODE   = 14;

  ////////////////////////////////////////////////////////////////////////
  // modes and states
  typedef enum logic [1:0] {
    FIFO_PHASE = 2'h0, FIFO_BASIC = 2'h1, FIFO_REG = 2'h2, FIFO_CLKCOMP = 2'h3
  } pcsdp_fifo_e;

  typedef enum logic [1:0] {
    CFG_CUSTOM = 2'h0, CFG_TENG = 2'h1, CFG_TENG_1588 = 2'h2, CFG_TENG_FEC = 2'h3
  } pcsdp_cfg_e;

  // gray order along loss -> acq1 -> acq2 -> sync
  typedef enum logic [1:0] {
    SYNC_LOSS = 2'h0, SYNC_ACQ1 = 2'h1, SYNC_ACQ2 = 2'h3, SYNC_OK = 2'h2
  } pcsdp_sync_e;

  typedef struct packed {
    logic        gear_uneven;
    pcsdp_fifo_e rx_mode;
    pcsdp_fifo_e tx_mode;
    pcsdp_cfg_e  cfg;
    logic        fec_en;
    logic        pcs_enh;
  } pcsdp_ctrl_s;

  typedef struct packed {
    logic [9:0] code;
    logic       rd;
  } pcsdp_enc_s;

  ////////////////////////////////////////////////////////////////////////
  // sequencing and latency
  localparam int           COMMA_MIN   = 3;
  localparam int           FEC_LAT_CYC = 40;
  localparam int           FEC_HALF    = FEC_LAT_CYC / 2;
  localparam logic         RD_NEG      = 1'b0;
  localparam logic [63:0]  IDLE_WORD   = 64'h0707_0707_0707_0707;

  ////////////////////////////////////////////////////////////////////////
  // 8b/10b tables, rd- column; rd+ is the complement when unbalanced
  localparam logic [7:0]   K28_5_BYTE  = 8'hBC;
  localparam logic [9:0]   K28_5_RDN   = 10'h0FA;
  localparam logic [9:0]   K28_5_RDP   = 10'h305;
  localparam logic [5:0]   K28_6B      = 6'h0F;
  localparam logic [5:0]   SPEC_6B     = 6'h38;
  localparam logic [3:0]   SPEC_4B     = 4'hC;
  localparam logic [3:0]   ALT7_4B     = 4'h7;
  localparam logic [5:0]   ENC6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0]   ENC4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  function automatic logic bal6(input logic [5:0] s);
    return $countones(s) == 3;
  endfunction

  function automatic logic bal4(input logic [3:0] s);
    return $countones(s) == 2;
  endfunction

  // rd: 1 = positive running disparity; only K28.y is a control group
  function automatic pcsdp_enc_s pcsdp_encode(input logic [7:0] d,
                                              input logic       k,
                                              input logic       rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd6;
    logic       alt;
    pcsdp_enc_s r;
    s6 = k ? K28_6B : ENC6[d[4:0]];
    if (rd && (!bal6(s6) || s6 == SPEC_6B))
      s6 = ~s6;
    rd6 = bal6(s6) ? rd : ~rd;
    alt = (d[7:5] == 3'h7) && !k &&
          (rd6 ? (d[4:0] inside {5'h0B, 5'h0D, 5'h0E})
               : (d[4:0] inside {5'h11, 5'h12, 5'h14}));
    s4 = alt ? ALT7_4B : ENC4[d[7:5]];
    if (k)
      s4 = rd6 ? s4 : ~s4;
    else if (rd6 && (!bal4(s4) || s4 == SPEC_4B))
      s4 = ~s4;
    r.code = {s6, s4};
    r.rd   = bal4(s4) ? rd6 : ~rd6;
    return r;
  endfunction

endpackage

// ===== rtl/pcsdp_core_fifo.sv
// Purpose: core fifo of the 64b/66b pcs with its four operating modes
// Assumes: both sides on pclk; mode held steady while traffic flows
// Notes:   flags are registered from the next level, so they match the count with no lag
`timescale 1ns/100ps
module pcsdp_core_fifo #(
  parameter int W          = 64,
  parameter int DEPTH      = 8,
  parameter int PFULL_LVL  = 6,
  parameter int PEMPTY_LVL = 2,
  parameter int PHASE_LVL  = 2
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire pcsdp_pkg::pcsdp_fifo_e mode,
  input  wire logic                 wr_en,
  input  wire logic [W-1:0]         wr_data,
  input  wire logic                 rd_en,
  output logic      [W-1:0]         rd_data,
  output logic                      rd_valid,
  output logic                      pfull,
  output logic                      pempty
);
  import pcsdp_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          full;
  logic          empty;
  logic          wr_ok;
  logic          rd_ok;
  logic          idle_ins;

  ////////////////////////////////////////////////////////////////////////
  assign full  = cnt_r == CW'(DEPTH);
  assign empty = cnt_r == '0;
  // full in clock compensation drops the word: that is the deletion
  assign wr_ok = wr_en && !full && mode != FIFO_REG;

  always_comb begin
    rd_ok    = 1'b0;
    idle_ins = 1'b0;
    case (mode)
      FIFO_PHASE:   rd_ok = cnt_r >= CW'(PHASE_LVL); // constant depth
      FIFO_BASIC:   rd_ok = rd_en && !empty;
      FIFO_CLKCOMP: begin
        rd_ok    = rd_en && !empty;
        idle_ins = rd_en && empty;
      end
      default:      rd_ok = 1'b0;
    endcase
  end

  assign cnt_nxt = cnt_r + CW'(wr_ok) - CW'(rd_ok);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (wr_ok)
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (rd_ok)
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_ok)
      mem_r[wp_r] <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else if (mode == FIFO_REG) begin
      // single register stage gives fixed latency
      rd_data  <= wr_data;
      rd_valid <= wr_en;
    end else if (idle_ins) begin
      rd_data  <= W'(IDLE_WORD);
      rd_valid <= 1'b1;
    end else begin
      rd_data  <= mem_r[rp_r];
      rd_valid <= rd_ok;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pfull  <= 1'b0;
      pempty <= 1'b1;
    end else begin
      pfull  <= cnt_nxt >= CW'(PFULL_LVL);
      pempty <= cnt_nxt <= CW'(PEMPTY_LVL);
    end
  end

endmodule

// ===== sim/pcsdp_chk.sv
// Purpose: port checker for pcsdp_top, channel 0
// Assumes: single pclk domain
// Notes:   comma set closed under inversion
`timescale 1ns/100ps
module pcsdp_chk import pcsdp_pkg::*; #(parameter int NCH = 2) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic tx_pcs_rst,
  input wire logic [NCH*8-1:0] tx_byte,
  input wire logic [NCH-1:0] tx_is_k,
  input wire logic [NCH-1:0] tx_forcedisp,
  input wire logic [NCH-1:0] tx_dispval,
  input wire logic [NCH-1:0] tx_polinv,
  input wire logic [NCH*10-1:0] tx_code,
  input wire logic tx_user_ready,
  input wire logic rx_pcs_rst,
  input wire logic [NCH*10-1:0] rx_code,
  input wire logic [NCH-1:0] rx_polinv,
  input wire logic [NCH*10-1:0] rx_word,
  input wire logic [NCH-1:0] rx_syncstatus
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic k0 = rx_code[9:0] == K28_5_RDN || rx_code[9:0] == K28_5_RDP;
  wire logic uk = tx_user_ready && tx_is_k[0] && !tx_polinv[0] &&
                  tx_byte[7:0] == K28_5_BYTE;
  //////////////////////////////////////////////////////////////////////
  sequence s_commas;
    tx_code[9:0] == K28_5_RDN ##1 tx_code[9:0] == K28_5_RDP
      ##1 tx_code[9:0] == K28_5_RDN;
  endsequence
  sequence s_kk;
    !rx_pcs_rst && k0 ##1 k0;
  endsequence
  property p_setup; psel && !penable |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_commas; $fell(tx_pcs_rst) |-> ##[1:2] s_commas; endproperty
  property p_rst; tx_pcs_rst |=> tx_code == '0; endproperty
  property p_alt;
    uk && !tx_forcedisp[0] ##1 uk && !tx_forcedisp[0]
      |=> tx_code[9:0] != $past(tx_code[9:0]);
  endproperty
  property p_force;
    uk && tx_forcedisp[0] && !tx_dispval[0] |=> tx_code[9:0] == K28_5_RDP;
  endproperty
  property p_loss; s_kk |=> !rx_syncstatus[0]; endproperty
  property p_rxpol;
    !rx_pcs_rst |=> rx_word[9:0] == ($past(rx_polinv[0]) ?
      ~$past(rx_code[9:0]) : $past(rx_code[9:0]));
  endproperty
  a_setup: assert property (p_setup) else $error("no pready");
  a_one: assert property (p_one) else $error("pready too long");
  a_commas: assert property (p_commas) else $error("bad commas");
  a_rst: assert property (p_rst) else $error("code in reset");
  a_alt: assert property (p_alt) else $error("no alternation");
  a_force: assert property (p_force) else $error("bad force");
  a_loss: assert property (p_loss) else $error("sync kept");
  a_rxpol: assert property (p_rxpol) else $error("bad rx word");
endmodule
bind pcsdp_top pcsdp_chk #(.NCH(NCH)) pcsdp_chk_inst (.*);

// ===== sim/pcsdp_link.sv
// Purpose: remote end, serial link folded back
// Assumes: straight wiring, one cycle of flight
// Notes:   no swap, so inversion is left to the device
`timescale 1ns/100ps
module pcsdp_link #(parameter int W = 20) (
  input wire logic clk,
  input wire logic [W-1:0] tx,
  output logic [W-1:0] rx
);
  always_ff @(posedge clk) begin
    rx <= tx;
  end
endmodule

// ===== sim/pcsdp_top_tb.sv
// Purpose: bench for pcsdp_top
// Assumes: zero wait apb, loopback link
// Notes:   enhanced lane free runs in loopback
`timescale 1ns/100ps
module pcsdp_top_tb;
  import pcsdp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic [31:0] prdata;
  logic pready, pslverr, tx_pcs_rst = 1, rx_pcs_rst = 1, tx_user_ready;
  logic [15:0] tx_byte = '0;
  logic [1:0] tx_is_k = '0, tx_forcedisp = '0, tx_dispval = '0;
  logic [1:0] tx_polinv = '0, rx_polinv = '0, rx_syncstatus;
  logic [19:0] tx_code, rx_code, rx_word;
  logic [63:0] tx_enh_data = '0, tx_enh_word, rx_enh_data;
  logic tx_enh_pfull, tx_enh_word_valid, rx_enh_data_valid, rx_enh_pempty;
  wire logic tx_enh_wr_en = ~tx_enh_pfull;
  wire logic rx_enh_read_en = ~rx_enh_pempty;
  wire logic [63:0] rx_enh_word_in = tx_enh_word;
  wire logic rx_enh_word_in_valid = tx_enh_word_valid;
  int err_count = 0, checks = 0;
  pcsdp_top pcsdp_top_inst (.*);
  pcsdp_link pcsdp_link_inst (.clk(pclk), .tx(tx_code), .rx(rx_code));
  always #2 pclk = ~pclk; // one core clock feeds both fifo sides
  always @(posedge pclk) tx_enh_data <= tx_enh_data + 64'h1;
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, exp, input string nm);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task send(input logic [7:0] b, input logic k, input int n);
    @(posedge pclk);
    tx_byte <= {b, b};
    tx_is_k <= {k, k};
    repeat (n) @(posedge pclk);
  endtask
  task tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, CTRL_OFS, '0); chk(rd, CTRL_RST, "ctrl");
    apb(1, CTRL_OFS, 32'h3); apb(0, LAT_OFS, '0);
    chk(rd, FEC_LAT_CYC, "lat");
    apb(1, CTRL_OFS, 32'h2); apb(0, LAT_OFS, '0);
    chk(rd, '0, "lat plain");
    apb(0, 8'h40, '0); chk(slv, 1, "slverr");
    $display("test apb done");
    rx_pcs_rst <= 0;
    tx_pcs_rst <= 0;
    repeat (6) @(posedge pclk);
    chk(tx_user_ready, 1, "tx ready");
    for (int i = 0; i < 8; i++) send(i[0] ? 8'h00 : K28_5_BYTE, !i[0], 0);
    repeat (5) @(posedge pclk);
    chk(rx_syncstatus, 2'h3, "sync");
    send(K28_5_BYTE, 1, 1);
    send(8'h00, 0, 4);
    chk(rx_syncstatus, 2'h0, "loss");
    $display("test sync done");
    tx_forcedisp <= 2'h3;
    send(K28_5_BYTE, 1, 3);
    chk(tx_code, {2{K28_5_RDP}}, "forced");
    tx_polinv <= 2'h3;
    repeat (3) @(posedge pclk);
    chk(tx_code, {2{K28_5_RDN}}, "tx inv");
    rx_polinv <= 2'h3;
    repeat (4) @(posedge pclk);
    chk(rx_word, {2{K28_5_RDP}}, "rx inv");
    $display("test polarity done");
    apb(1, CTRL_OFS, 32'h51);
    repeat (20) @(posedge pclk);
    chk(rx_enh_data_valid, 1, "rx valid");
    chk({tx_enh_pfull, rx_enh_pempty}, 0, "flags");
    rd = rx_enh_data[31:0];
    @(posedge pclk);
    chk(rx_enh_data[31:0], rd + 32'h1, "rx stream");
    apb(1, CTRL_OFS, 32'h0D);
    apb(0, STATUS_OFS, '0);
    chk(rd[15:11], 5'h19, "eff modes");
    $display("test enhanced done");
    tally_and_finish;
  end
endmodule
